// >>> bench/cbmc_far_end.sv
`default_nettype none
module cbmc_far_end (
  // Clock and converter state
  input wire logic i_clock,
  input wire logic i_switch_en,
  // Bench-held levels, pin vector low bits
  input wire logic [8:0] i_env,
  // Pins in input index order
  output logic [10:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  logic [2:0] age = 3'h0;
  // Light load: current decays while switching, output sags once idle
  always_ff @(posedge i_clock) begin
    last <= i_switch_en;
    age <= (last != i_switch_en) ? 3'h0 : ((age == 3'h7) ? age : age + 3'h1);
  end
  assign o_pins = {!i_switch_en && age > 3'h2, i_switch_en && age > 3'h2, i_env};
endmodule
`default_nettype wire

// >>> bench/cbmc_properties.sv
`include "cbmc_cfg.svh"
`default_nettype none
module cbmc_properties #(
  parameter int P_TICK_CYCLES = 2,
  parameter int P_SAFETY_TICKS = 20,
  parameter int P_OVERLOAD_TICKS = 5,
  parameter int P_PULSE_TICKS = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  // Plant levels
  input wire logic i_bus_above_uvlo,
  input wire logic i_bus_overvoltage,
  input wire logic i_boost_overload,
  input wire logic i_bat_above_max,
  input wire logic i_bat_below_min,
  input wire logic i_thermal_shutdown,
  // Converter state
  input wire cbmc_pkg::cbmc_mode_t o_mode,
  input wire logic o_charge_en,
  input wire logic o_switch_en,
  input wire logic o_host_absent,
  input wire logic o_stat_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import cbmc_pkg::*;
  // ==========================================================
  // Bounds; slack covers input sync, tick phase and mode register
  localparam int SAFE_MAX = (P_SAFETY_TICKS + 1) * P_TICK_CYCLES + 4;
  localparam int OVL_MAX = (P_OVERLOAD_TICKS + 2) * P_TICK_CYCLES + 4;
  localparam int OE_MAX = (P_PULSE_TICKS + 1) * P_TICK_CYCLES + 4;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);
  logic kick;
  logic boost;
  int boost_cnt;
  int ovl_cnt;
  int oe_cnt;
  assign boost = (o_mode == CBMC_BOOST);
  assign kick = i_psel & i_penable & i_pwrite & o_pready & (i_paddr == `CBMC_CTRL_OFS)
    & i_pwdata[`CBMC_CTRL_KICK];
  // Restarting early only undercounts, so it can never fire falsely
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      boost_cnt <= 0;
      ovl_cnt <= 0;
      oe_cnt <= 0;
    end else begin
      boost_cnt <= (boost && !kick && !i_thermal_shutdown) ? boost_cnt + 1 : 0;
      ovl_cnt <= (boost && i_boost_overload && !i_thermal_shutdown) ? ovl_cnt + 1 : 0;
      oe_cnt <= (o_stat_oe && !(o_mode == CBMC_CHARGE) && !i_thermal_shutdown) ? oe_cnt + 1 : 0;
    end
  end
  // ==========================================================
  // Sequences
  sequence s_bus_ov;
    i_bus_overvoltage && boost;
  endsequence
  sequence s_bat_out;
    (i_bat_above_max || i_bat_below_min) && boost;
  endsequence
  sequence s_absent_low;
    o_host_absent && !i_bus_above_uvlo;
  endsequence
  // ==========================================================
  // Properties
  a_pready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready not high after setup");
  a_charge_en_mode: assert property (o_charge_en |->
    (o_mode == CBMC_CHARGE || $past(o_mode) == CBMC_CHARGE))
    else $error("charge enable outside charge mode");
  a_switch_in_boost: assert property (o_switch_en |-> (boost || $past(boost)))
    else $error("switching outside boost");
  a_safety_bound: assert property (boost_cnt <= SAFE_MAX)
    else $error("boost outlived safety timer");
  a_overload_bound: assert property (ovl_cnt <= OVL_MAX)
    else $error("overload not declared in time");
  a_pulse_width: assert property (oe_cnt <= OE_MAX)
    else $error("fault pulse too long");
  a_bus_ov_exit: assert property (s_bus_ov |-> ##[1:4] !boost)
    else $error("boost kept on bus overvoltage");
  a_bat_range_exit: assert property (s_bat_out |-> ##[1:4] !boost)
    else $error("boost kept with battery out of range");
  a_absent_hiz: assert property (s_absent_low [*4] |-> o_mode == CBMC_HIZ)
    else $error("host absent below lockout not hiz");
  a_absent_from_hiz: assert property ($rose(o_host_absent) |-> $past(o_mode) == CBMC_HIZ)
    else $error("host absent entered outside hiz");
  a_thermal_stop: assert property (i_thermal_shutdown [*3] |=> !o_switch_en)
    else $error("switching during thermal shutdown");
endmodule
bind cbmc_top cbmc_properties #(
  .P_TICK_CYCLES(P_TICK_CYCLES),
  .P_SAFETY_TICKS(P_SAFETY_TICKS),
  .P_OVERLOAD_TICKS(P_OVERLOAD_TICKS),
  .P_PULSE_TICKS(P_PULSE_TICKS)
) u_props (.*);
`default_nettype wire

// >>> bench/charger_boost_mode_control_test.sv
`include "cbmc_cfg.svh"
`default_nettype none
module charger_boost_mode_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cbmc_pkg::*;
  localparam logic [7:0] CTL = `CBMC_CTRL_OFS;
  localparam logic [7:0] FLT = `CBMC_FAULT_OFS;
  localparam logic [7:0] PAR = `CBMC_PARAM_OFS;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pd = 32'h0;
  // Plant levels; bus above lockout from the start
  logic [8:0] env = 9'h002;
  logic [10:0] pins;
  logic pready, pslverr, charge_en, boost_en, sw_en, absent, stat_o, stat_oe;
  logic [31:0] prdata;
  cbmc_mode_t mode;
  wire logic stat_pin;
  int err_total = 0;
  int n_compared = 0;
  // Open-drain pin with pull-up
  assign stat_pin = stat_oe ? stat_o : 1'b1;
  always #2.5 clk = ~clk;
  cbmc_far_end u_far (.i_clock(clk), .i_switch_en(sw_en), .i_env(env), .o_pins(pins));
  cbmc_top #(.P_TICK_CYCLES(2), .P_SAFETY_TICKS(20), .P_CRUDE_TICKS(20),
    .P_OVERLOAD_TICKS(5), .P_PULSE_TICKS(4)) DUT (
    .i_clock(clk), .i_arst_n(rst_n), .i_clk_en(clk_en),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pd),
    .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
    .i_otg_active(pins[CBMC_IN_OTG]), .i_bus_above_uvlo(pins[CBMC_IN_UVLO_OK]),
    .i_bus_overvoltage(pins[CBMC_IN_BUS_OV]), .i_boost_overload(pins[CBMC_IN_OVERLOAD]),
    .i_bat_above_max(pins[CBMC_IN_BAT_MAX]), .i_bat_below_min(pins[CBMC_IN_BAT_MIN]),
    .i_bat_below_weak(pins[CBMC_IN_BAT_WEAK]), .i_charge_fault(pins[CBMC_IN_CHG_FAULT]),
    .i_thermal_shutdown(pins[CBMC_IN_THERMAL]), .i_inductor_low(pins[CBMC_IN_IND_LOW]),
    .i_boost_output_low(pins[CBMC_IN_OUT_LOW]), .o_mode(mode), .o_charge_en(charge_en),
    .o_boost_en(boost_en), .o_switch_en(sw_en), .o_host_absent(absent),
    .o_stat_o(stat_o), .o_stat_oe(stat_oe));
  // ==========================================================
  // Tasks
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(32'(e), 32'(a > PAR));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk(32'(e), 32'(a > PAR));
  endtask
  task automatic wait_mode(input cbmc_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(32'(mode), 32'(m));
    if (mode !== m) end_sim();
  endtask
  // Switching must stop and resume under light load
  task automatic sw_cycle();
    logic prev;
    int rises;
    rises = 0;
    prev = sw_en;
    repeat (16) begin
      @(posedge clk);
      if (sw_en === 1'b1 && prev === 1'b0) rises++;
      prev = sw_en;
    end
    chk(32'(rises > 0), 32'h1);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(CTL, 32'h0);
    rd(FLT, 32'h0);
    rd(PAR, 32'h0A);
    wr(8'h10, 32'hFF);
    rd(8'h10, 32'h0);
    wait_mode(CBMC_CHARGE);
    rd(`CBMC_STATUS_OFS, 32'h41);
    // Frozen clock enable: a lockout drop must go unseen
    clk_en <= 1'b0;
    env[CBMC_IN_UVLO_OK] <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(mode), 32'(CBMC_CHARGE));
    clk_en <= 1'b1;
    wait_mode(CBMC_HIZ);
    env[CBMC_IN_UVLO_OK] <= 1'b1;
    wait_mode(CBMC_CHARGE);
    wr(CTL, 32'h01);
    repeat (3) @(posedge clk);
    chk(32'(charge_en), 32'h0);
    wr(CTL, 32'h20);
    repeat (3) @(posedge clk);
    chk(32'(charge_en), 32'h1);
    chk(32'(stat_pin), 32'h0);
    wr(PAR, 32'h55);
    rd(PAR, 32'h55);
    wr(CTL, 32'h01);
    wr(CTL, 32'h03);
    rd(CTL, 32'h01);
    rd(PAR, 32'h0A);
    wr(CTL, 32'h00);
    env[CBMC_IN_CHG_FAULT] <= 1'b1;
    wait_mode(CBMC_CONFIG);
    rd(FLT, 32'h10);
    env[CBMC_IN_CHG_FAULT] <= 1'b0;
    // Let the synchronised fault drop first, or it sets again
    repeat (3) @(posedge clk);
    wr(FLT, 32'h3F);
    wait_mode(CBMC_CHARGE);
    wr(CTL, 32'h08);
    wait_mode(CBMC_BOOST);
    chk(32'(boost_en), 32'h1);
    sw_cycle();
    chk(32'(stat_pin), 32'h1);
    for (int i = 0; i < 3; i++) begin
      repeat (10) @(posedge clk);
      wr(CTL, 32'h18);
    end
    chk(32'(mode), 32'(CBMC_BOOST));
    rd(CTL, 32'h08);
    wait_mode(CBMC_CONFIG);
    repeat (2) @(posedge clk);
    chk(32'(stat_pin), 32'h0);
    repeat (60) @(posedge clk);
    chk(32'(mode), 32'(CBMC_CONFIG));
    rd(FLT, 32'h01);
    wr(FLT, 32'h01);
    wait_mode(CBMC_BOOST);
    env[CBMC_IN_BUS_OV] <= 1'b1;
    wait_mode(CBMC_CONFIG);
    rd(CTL, 32'h00);
    rd(FLT, 32'h02);
    env[CBMC_IN_BUS_OV] <= 1'b0;
    wr(FLT, 32'h3F);
    wait_mode(CBMC_CHARGE);
    env[CBMC_IN_OTG] <= 1'b1;
    wait_mode(CBMC_BOOST);
    for (int i = 0; i < 2; i++) begin
      env[(i == 0) ? CBMC_IN_BAT_MAX : CBMC_IN_BAT_MIN] <= 1'b1;
      wait_mode(CBMC_CONFIG);
      rd(FLT, 32'h08);
      env[CBMC_IN_BAT_MAX] <= 1'b0;
      env[CBMC_IN_BAT_MIN] <= 1'b0;
      wr(FLT, 32'h08);
      wait_mode(CBMC_BOOST);
    end
    env[CBMC_IN_THERMAL] <= 1'b1;
    wait_mode(CBMC_CONFIG);
    chk(32'(sw_en), 32'h0);
    env[CBMC_IN_THERMAL] <= 1'b0;
    repeat (3) @(posedge clk);
    wr(FLT, 32'h3F);
    env[CBMC_IN_OTG] <= 1'b0;
    wr(CTL, 32'h08);
    wait_mode(CBMC_BOOST);
    env[CBMC_IN_OVERLOAD] <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(mode), 32'(CBMC_BOOST));
    wait_mode(CBMC_CONFIG);
    rd(CTL, 32'h00);
    rd(FLT, 32'h04);
    env[CBMC_IN_OVERLOAD] <= 1'b0;
    wr(CTL, 32'h08);
    repeat (10) @(posedge clk);
    chk(32'(mode), 32'(CBMC_CONFIG));
    wr(FLT, 32'h04);
    wait_mode(CBMC_BOOST);
    wr(CTL, 32'h0C);
    wait_mode(CBMC_HIZ);
    wr(CTL, 32'h00);
    env[CBMC_IN_UVLO_OK] <= 1'b0;
    env[CBMC_IN_BAT_WEAK] <= 1'b1;
    wait_mode(CBMC_HIZ);
    repeat (60) @(posedge clk);
    chk(32'(absent), 32'h1);
    env[CBMC_IN_OTG] <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(mode), 32'(CBMC_HIZ));
    wr(CTL, 32'h00);
    wait_mode(CBMC_BOOST);
    chk(32'(absent), 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire

// >>> design/cbmc_cfg.svh
`ifndef CBMC_CFG_SVH
`define CBMC_CFG_SVH
// ==========================================================
// Timing
`define CBMC_CLK_PERIOD_NS 5
`define CBMC_TICK_US 1
`define CBMC_SAFETY_TIME_S 32
`define CBMC_CRUDE_TIME_S 32
`define CBMC_OVERLOAD_TIME_MS 30
`define CBMC_FAULT_PULSE_US 128
// ==========================================================
// Register byte offsets
`define CBMC_CTRL_OFS 8'h00
`define CBMC_STATUS_OFS 8'h04
`define CBMC_FAULT_OFS 8'h08
`define CBMC_PARAM_OFS 8'h0C
// ==========================================================
// Control field positions
`define CBMC_CTRL_CHG_DIS 0
`define CBMC_CTRL_PARAM_RST 1
`define CBMC_CTRL_HIZ_SEL 2
`define CBMC_CTRL_BOOST_SEL 3
`define CBMC_CTRL_KICK 4
`define CBMC_CTRL_STAT_EN 5
// Fault field positions
`define CBMC_FLT_TIMER 0
`define CBMC_FLT_BUS_OV 1
`define CBMC_FLT_OVERLOAD 2
`define CBMC_FLT_BAT_RANGE 3
`define CBMC_FLT_CHARGE 4
`define CBMC_FLT_THERMAL 5
// ==========================================================
// Reset values
`define CBMC_CTRL_RESET 6'h00
`define CBMC_PARAM_RESET 8'h0A
`endif

// >>> design/cbmc_pkg.sv
`default_nettype none
package cbmc_pkg;
  // Operating mode, Gray coded along hiz-charge-cfg-boost
  typedef enum logic [2:0] {
    CBMC_HIZ = 3'h0,
    CBMC_CHARGE = 3'h1,
    CBMC_CONFIG = 3'h3,
    CBMC_BOOST = 3'h2
  } cbmc_mode_t;
  // Analog comparator inputs, bit positions in the sync vector
  typedef enum int {
    CBMC_IN_OTG = 0,
    CBMC_IN_UVLO_OK = 1,
    CBMC_IN_BUS_OV = 2,
    CBMC_IN_OVERLOAD = 3,
    CBMC_IN_BAT_MAX = 4,
    CBMC_IN_BAT_MIN = 5,
    CBMC_IN_BAT_WEAK = 6,
    CBMC_IN_CHG_FAULT = 7,
    CBMC_IN_THERMAL = 8,
    CBMC_IN_IND_LOW = 9,
    CBMC_IN_OUT_LOW = 10,
    CBMC_IN_COUNT = 11
  } cbmc_in_t;
endpackage
`default_nettype wire

// >>> design/cbmc_top.sv
// Behaviour
// - charge-disable bit 0 charges, 1 stops charging
// - parameter reset restores defaults, then self-clears
// - no boost/hiz: charge, configure or hiz
// - boost select: boost unless fault, then configure
// - hiz bit with OTG inactive forces hiz
// - host mode: OTG or boost select boosts
// - light load skip below 75 mA, resume
// - 32 s safety timer starts with boost
// - kick bit restarts timer, then self-clears
// - timer expiry stops boost, pulses, flags fault
// - timer fault held until reset or clear
// - bus overvoltage stops boost, clears select
// - overload beyond 30 ms declares overload fault
// - overload keeps boost off until cleared
// - battery out of range stops boost
// - boosting leaves status open; faults pulse 128 us
// - crude 32 s timer in hiz, weak battery
// - crude expiry enters host-absent, stops crude timer
// - host-absent: bus below lockout forces hiz
// - thermal shutdown stops switching, freezes safety and crude timers, clears overload count
// - status low while charging with enable set
//
// The register offsets and the APB register port were chosen for this implementation.
`include "cbmc_cfg.svh"
`default_nettype none
module cbmc_top #(
  parameter int P_TICK_CYCLES = (`CBMC_TICK_US * 1000) / `CBMC_CLK_PERIOD_NS,
  parameter int P_SAFETY_TICKS = (`CBMC_SAFETY_TIME_S * 1000000) / `CBMC_TICK_US,
  parameter int P_CRUDE_TICKS = (`CBMC_CRUDE_TIME_S * 1000000) / `CBMC_TICK_US,
  parameter int P_OVERLOAD_TICKS =
    (`CBMC_OVERLOAD_TIME_MS * 1000 + `CBMC_TICK_US - 1) / `CBMC_TICK_US,
  parameter int P_PULSE_TICKS = `CBMC_FAULT_PULSE_US / `CBMC_TICK_US
) (
  // Clock, reset, enable
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // Comparator and pin inputs, asynchronous
  input wire logic i_otg_active,
  input wire logic i_bus_above_uvlo,
  input wire logic i_bus_overvoltage,
  input wire logic i_boost_overload,
  input wire logic i_bat_above_max,
  input wire logic i_bat_below_min,
  input wire logic i_bat_below_weak,
  input wire logic i_charge_fault,
  input wire logic i_thermal_shutdown,
  input wire logic i_inductor_low,
  input wire logic i_boost_output_low,
  // Converter control
  output cbmc_pkg::cbmc_mode_t o_mode,
  output logic o_charge_en,
  output logic o_boost_en,
  output logic o_switch_en,
  output logic o_host_absent,
  // Status pin, open drain
  output logic o_stat_o,
  output logic o_stat_oe
);
  import cbmc_pkg::*;

  localparam int NIN = CBMC_IN_COUNT;
  localparam int TW = $clog2(P_TICK_CYCLES + 1);
  localparam int SW = $clog2(P_SAFETY_TICKS + 1);
  localparam int CW = $clog2(P_CRUDE_TICKS + 1);
  localparam int OW = $clog2(P_OVERLOAD_TICKS + 2);
  localparam int PW = $clog2(P_PULSE_TICKS + 1);

  generate
    if (P_TICK_CYCLES < 1 || P_SAFETY_TICKS < 1 || P_CRUDE_TICKS < 1 ||
        P_OVERLOAD_TICKS < 1 || P_PULSE_TICKS < 1) begin : g_bad
      $error("cbmc_top: every count parameter must be at least 1");
    end
  endgenerate

  // ==========================================================
  // Input synchronisers
  logic [NIN-1:0] sync1_reg;
  logic [NIN-1:0] sync2_reg;
  wire [NIN-1:0] raw_in = {i_boost_output_low, i_inductor_low, i_thermal_shutdown,
                           i_charge_fault, i_bat_below_weak, i_bat_below_min,
                           i_bat_above_max, i_boost_overload, i_bus_overvoltage,
                           i_bus_above_uvlo, i_otg_active};

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (i_clk_en) begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire otg = sync2_reg[CBMC_IN_OTG];
  wire uvlo_ok = sync2_reg[CBMC_IN_UVLO_OK];
  wire bus_ov = sync2_reg[CBMC_IN_BUS_OV];
  wire overload = sync2_reg[CBMC_IN_OVERLOAD];
  wire bat_bad = sync2_reg[CBMC_IN_BAT_MAX] | sync2_reg[CBMC_IN_BAT_MIN];
  wire bat_weak = sync2_reg[CBMC_IN_BAT_WEAK];
  wire chg_fault = sync2_reg[CBMC_IN_CHG_FAULT];
  wire thermal = sync2_reg[CBMC_IN_THERMAL];
  wire ind_low = sync2_reg[CBMC_IN_IND_LOW];
  wire out_low = sync2_reg[CBMC_IN_OUT_LOW];

  // ==========================================================
  // Tick prescaler
  logic [TW-1:0] presc_reg;
  wire tick_wrap = (presc_reg == TW'(P_TICK_CYCLES - 1));
  // Safety and crude timers hold their counts while hot; overload count clears once boost exits
  wire tick = tick_wrap & ~thermal;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      presc_reg <= '0;
    end else if (i_clk_en) begin
      presc_reg <= tick_wrap ? '0 : presc_reg + TW'(1);
    end
  end

  // ==========================================================
  // APB decode
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [5:0] ctrl_reg;
  logic [5:0] ctrl_next;
  logic [5:0] fault_reg;
  logic [5:0] fault_next;
  logic [7:0] param_reg;
  cbmc_mode_t mode_reg;
  cbmc_mode_t mode_next;
  logic host_absent_reg;
  logic sw_on_reg;
  logic charge_en_reg;

  wire setup = i_psel & ~i_penable;
  wire wr_fire = i_psel & i_penable & i_pwrite & pready_reg;
  wire hit_ctrl = (i_paddr == `CBMC_CTRL_OFS);
  wire hit_status = (i_paddr == `CBMC_STATUS_OFS);
  wire hit_fault = (i_paddr == `CBMC_FAULT_OFS);
  wire hit_param = (i_paddr == `CBMC_PARAM_OFS);
  wire hit_any = hit_ctrl | hit_status | hit_fault | hit_param;
  wire wr_ctrl = wr_fire & hit_ctrl;
  wire wr_fault = wr_fire & hit_fault;
  wire wr_param = wr_fire & hit_param;

  wire [31:0] status_word = {25'h0000000, charge_en_reg, otg, sw_on_reg,
                             host_absent_reg, mode_reg};
  wire [31:0] rd_word = hit_ctrl ? {26'h0000000, ctrl_reg} :
                        hit_status ? status_word :
                        hit_fault ? {26'h0000000, fault_reg} :
                        hit_param ? {24'h000000, param_reg} : 32'h0000_0000;

  // Zero-wait: answer registered in setup, ready in first access cycle
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (i_clk_en) begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~hit_any;
      if (setup) begin
        prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // ==========================================================
  // Fault detection
  logic [SW-1:0] safety_reg;
  logic [OW-1:0] ovl_reg;
  logic [CW-1:0] crude_reg;
  logic [PW-1:0] pulse_reg;

  wire in_boost = (mode_reg == CBMC_BOOST);
  wire in_charge = (mode_reg == CBMC_CHARGE) || (mode_reg == CBMC_CONFIG);
  wire safety_done = in_boost & tick & (safety_reg == SW'(P_SAFETY_TICKS - 1));
  wire ovl_done = in_boost & (ovl_reg > OW'(P_OVERLOAD_TICKS));
  wire bus_ov_evt = in_boost & bus_ov;
  wire bat_evt = in_boost & bat_bad;

  logic [5:0] fault_set;
  always_comb begin
    fault_set = '0;
    fault_set[`CBMC_FLT_TIMER] = safety_done;
    fault_set[`CBMC_FLT_BUS_OV] = bus_ov_evt;
    fault_set[`CBMC_FLT_OVERLOAD] = ovl_done;
    fault_set[`CBMC_FLT_BAT_RANGE] = bat_evt;
    fault_set[`CBMC_FLT_CHARGE] = in_charge & chg_fault;
    fault_set[`CBMC_FLT_THERMAL] = thermal;
  end

  // Set wins over a write-one-to-clear in the same cycle
  assign fault_next = (fault_reg & ~(wr_fault ? i_pwdata[5:0] : 6'h00)) | fault_set;
  wire fault_new = |(fault_set & ~fault_reg);
  wire boost_stop_evt = bus_ov_evt | ovl_done | bat_evt;

  // ==========================================================
  // Control register
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = i_pwdata[5:0];
    end else begin
      ctrl_next[`CBMC_CTRL_PARAM_RST] = 1'b0;
      ctrl_next[`CBMC_CTRL_KICK] = 1'b0;
    end
    if (boost_stop_evt) begin
      ctrl_next[`CBMC_CTRL_BOOST_SEL] = 1'b0;
    end
  end

  wire param_rst = ctrl_reg[`CBMC_CTRL_PARAM_RST];
  wire kick = ctrl_reg[`CBMC_CTRL_KICK];
  wire boost_sel = ctrl_reg[`CBMC_CTRL_BOOST_SEL];
  wire hiz_sel = ctrl_reg[`CBMC_CTRL_HIZ_SEL];

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg <= `CBMC_CTRL_RESET;
      fault_reg <= '0;
    end else if (i_clk_en) begin
      ctrl_reg <= ctrl_next;
      fault_reg <= fault_next;
    end
  end

  // Charge parameters; a pending reset beats a same-cycle write
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      param_reg <= `CBMC_PARAM_RESET;
    end else if (i_clk_en) begin
      if (param_rst) begin
        param_reg <= `CBMC_PARAM_RESET;
      end else if (wr_param) begin
        param_reg <= i_pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Mode selection
  wire boost_req = ~host_absent_reg & (otg | boost_sel);
  wire boost_blocked = bus_ov | bat_bad | thermal | fault_reg[`CBMC_FLT_TIMER] |
                       fault_reg[`CBMC_FLT_OVERLOAD];
  wire chg_blocked = chg_fault | thermal;

  always_comb begin
    mode_next = CBMC_HIZ;
    if (hiz_sel & ~otg) begin
      mode_next = CBMC_HIZ;
    end else if (host_absent_reg & ~uvlo_ok) begin
      mode_next = CBMC_HIZ;
    end else if (boost_req) begin
      mode_next = (boost_blocked | boost_stop_evt | safety_done) ?
                  CBMC_CONFIG : CBMC_BOOST;
    end else if (~uvlo_ok) begin
      mode_next = CBMC_HIZ;
    end else begin
      mode_next = chg_blocked ? CBMC_CONFIG : CBMC_CHARGE;
    end
  end

  wire boost_entry = (mode_next == CBMC_BOOST) & ~in_boost;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_reg <= CBMC_HIZ;
    end else if (i_clk_en) begin
      mode_reg <= mode_next;
    end
  end

  // ==========================================================
  // Timers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      safety_reg <= '0;
    end else if (i_clk_en) begin
      if (boost_entry | kick) begin
        safety_reg <= '0;
      end else if (in_boost & tick) begin
        safety_reg <= safety_done ? '0 : safety_reg + SW'(1);
      end
    end
  end

  // Overload persistence; stops counting once past the limit
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ovl_reg <= '0;
    end else if (i_clk_en) begin
      if (~in_boost | ~overload) begin
        ovl_reg <= '0;
      end else if (tick & ~ovl_done) begin
        ovl_reg <= ovl_reg + OW'(1);
      end
    end
  end

  // Host presence; any bus write counts as host control returning
  wire crude_run = (mode_reg == CBMC_HIZ) & bat_weak & ~host_absent_reg;
  wire crude_done = crude_run & tick & (crude_reg == CW'(P_CRUDE_TICKS - 1));

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      crude_reg <= '0;
      host_absent_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (crude_done) begin
        host_absent_reg <= 1'b1;
      end else if (wr_fire) begin
        host_absent_reg <= 1'b0;
      end
      if (~crude_run | crude_done) begin
        crude_reg <= '0;
      end else if (tick) begin
        crude_reg <= crude_reg + CW'(1);
      end
    end
  end

  // ==========================================================
  // Light-load pulse skipping
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sw_on_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (mode_next != CBMC_BOOST) begin
        sw_on_reg <= 1'b0;
      end else if (~in_boost) begin
        sw_on_reg <= 1'b1;
      end else if (sw_on_reg & ind_low) begin
        sw_on_reg <= 1'b0;
      end else if (~sw_on_reg & out_low) begin
        sw_on_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Status pin and converter outputs
  wire pulse_busy = (pulse_reg != '0);
  wire charging = (mode_next == CBMC_CHARGE) & ~ctrl_next[`CBMC_CTRL_CHG_DIS];
  // A new fault during a pulse restarts it, stretching the pulse with no gap on the pin
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pulse_reg <= '0;
    end else if (i_clk_en) begin
      if (fault_new) begin
        pulse_reg <= PW'(P_PULSE_TICKS);
      end else if (pulse_busy & tick_wrap) begin
        pulse_reg <= pulse_reg - PW'(1);
      end
    end
  end

  logic stat_oe_reg;
  logic boost_en_reg;
  logic switch_en_reg;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_oe_reg <= 1'b0;
      charge_en_reg <= 1'b0;
      boost_en_reg <= 1'b0;
      switch_en_reg <= 1'b0;
    end else if (i_clk_en) begin
      stat_oe_reg <= fault_new | (pulse_busy & ~(pulse_reg == PW'(1) & tick_wrap)) |
                     (charging & ctrl_next[`CBMC_CTRL_STAT_EN]);
      charge_en_reg <= charging;
      boost_en_reg <= (mode_next == CBMC_BOOST);
      switch_en_reg <= (mode_next == CBMC_BOOST) & ~thermal &
                       ((mode_reg != CBMC_BOOST) | (sw_on_reg ? ~ind_low : out_low));
    end
  end

  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_prdata = prdata_reg;
  assign o_mode = mode_reg;
  assign o_charge_en = charge_en_reg;
  assign o_boost_en = boost_en_reg;
  assign o_switch_en = switch_en_reg;
  assign o_host_absent = host_absent_reg;
  assign o_stat_o = 1'b0;
  assign o_stat_oe = stat_oe_reg;
endmodule
`default_nettype wire
